// ---- src/octal_driver_defs.svh ----
// Constants for the eight-channel low-side driver mode control block
// Summary of operation
// R1 - An overloaded output switches off and stays latched off until cleared.
// R2 - Overload must persist at least 3 us before a channel latches off.
// R3 - A latched fault clears by standby command on that channel or power-on reset.
// R4 - Fault detection runs continuously, during turn-on and while conducting.
// R5 - Each rising enable performs a full power-up reset to default values.
// R6 - Each channel takes its own command; 11 is off, 10 is on.
// R7 - Command 01 follows the parallel input; 00 is standby, off, no diagnostic current.
// R8 - After power-on reset commands are all ones, status zero, frame error flag one.
// R9 - Operation needs both supplies; in limp-home only the analog supply reset applies.
// R10 - Initial power-up gives global off without diagnostic current; other entries enable it. Code keeps it off after every entry until a command write.
// R11 - Undervoltage keeps outputs off; exit with limp-home high enters limp-home.
// R12 - Enable and limp-home both low select the lowest quiescent state.
// R13 - Standby on all channels adds a reduced quiescent current state.
// R14 - Parallel input n drives channels n and n+4 when programmed for parallel mode.
// R15 - A channel commanded off ignores its paired parallel input.
// R16 - The host clears faults latched during parallel pulse operation by command.
// R17 - Limp-home high: channels 1-4 follow inputs 1-4, channels 5-8 forced off.
// R18 - Limp-home ignores commands, keeps fault sensing; toggling limp-home re-enables channels.
// R19 - Leaving limp-home resets registers, enters off or low quiescent, diagnostics disabled.
// R20 - Analog supply reset forces outputs off; limp-home digital dropout keeps faults.
// R21 - Going from limp-home into global off sets the frame error flag.
// R22 - Enable rising with limp-home low moves low quiescent state into global off.
// R23 - Power-up is enable OR limp-home; rising limp-home enters limp-home regardless.
// R24 - Two command bits and two status bits per channel.
// R25 - Faults clear per channel in standby, all on supply reset, enable low, limp exit.
// R26 - Enable, limp-home and parallel inputs are synchronised before use.
`ifndef OCTAL_DRIVER_DEFS_SVH
`define OCTAL_DRIVER_DEFS_SVH

`define REG_COMMAND 4'h0
`define REG_FAULT 4'h4
`define REG_MODE 4'h8
`define CMD_RESET 16'hffff
`define CMD_ALL_STANDBY 16'h0000
`define REF_CLK_PERIOD_NS 25
`define OVL_FILTER_NS 3000
`define OVL_FILTER_CYC ((`OVL_FILTER_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)

`endif

// ---- src/octal_driver_pkg.sv ----
// Types shared by the driver mode control block
package octal_driver_pkg;
  typedef enum logic [1:0] {
    ST_UVLO = 2'b00,
    ST_LOW_IQ = 2'b01,
    ST_ACTIVE = 2'b10,
    ST_LIMP = 2'b11
  } mode_t;

  typedef enum logic [1:0] {
    CMD_STANDBY = 2'b00,
    CMD_PARALLEL = 2'b01,
    CMD_ON = 2'b10,
    CMD_OFF = 2'b11
  } chan_cmd_t;

  typedef struct packed {
    logic en;
    logic limp;
    logic [3:0] par;
    logic [7:0] ovl;
    logic [7:0] otp;
    logic dig_ok;
    logic ana_ok;
  } pins_t;
endpackage

// ---- src/octal_driver_channel_mode_control.sv ----
// Channel mode, protection and register control for the eight-channel low-side driver
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "octal_driver_defs.svh"

module octal_driver_channel_mode_control #(
  parameter int unsigned FILTER_CYCLES = `OVL_FILTER_CYC
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic EN,
  input wire logic LIMP_HOME_INPUT,
  input wire logic [3:0] PAR_IN,
  input wire logic [7:0] OVERLOAD_DET,
  input wire logic [7:0] OVERTEMP_DET,
  input wire logic DIGITAL_SUPPLY_OK,
  input wire logic ANALOG_SUPPLY_OK,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  output logic [7:0] LOW_SIDE_OUTPUTS,
  output logic [7:0] DIAG_CURRENT_EN,
  output logic REDUCED_IQ,
  output logic [1:0] MODE
);

  octal_driver_pkg::pins_t pin_meta;
  octal_driver_pkg::pins_t pins;
  logic en_d;
  logic limp_d;
  logic en_rise;
  octal_driver_pkg::mode_t state;
  octal_driver_pkg::mode_t next_state;
  logic [15:0] cmd;
  logic frame_error_flag;
  logic diag_armed;
  logic enter_active;
  logic wipe;
  logic clr_all;
  logic wr_cmd;
  logic [7:0] ovl_trip;
  logic [7:0] ovl_flt;
  logic [7:0] otp_flt;
  logic [7:0] fault;
  logic [7:0] next_out;
  logic [7:0] next_diag;
  logic [7:0] ovl_cnt [8];
  logic [8:0] ovl_run;

  // Counter is eight bits wide, so the filter count must stay at or below 256
  function automatic logic chan_drive(input logic [1:0] c, input logic par);
    case (c)
      octal_driver_pkg::CMD_ON: chan_drive = 1'b1;
      octal_driver_pkg::CMD_PARALLEL: chan_drive = par;
      default: chan_drive = 1'b0;
    endcase
  endfunction

  // A channel in standby while active drops its latched faults
  function automatic logic standby_clear(input octal_driver_pkg::mode_t s,
                                         input logic [1:0] c);
    standby_clear = s == octal_driver_pkg::ST_ACTIVE && c == octal_driver_pkg::CMD_STANDBY;
  endfunction

  function automatic logic [15:0] read_mux(input logic [3:0] a, input logic [15:0] c,
                                           input logic [15:0] f, input logic [4:0] m);
    case (a)
      `REG_COMMAND: read_mux = c;
      `REG_FAULT: read_mux = f;
      `REG_MODE: read_mux = {11'h000, m};
      default: read_mux = 16'h0000;
    endcase
  endfunction

  // Two-stage synchronisers for every pin from outside the clock domain
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      pin_meta <= '0;
      pins <= '0;
    end else begin
      pin_meta <= {EN, LIMP_HOME_INPUT, PAR_IN, OVERLOAD_DET, OVERTEMP_DET,
                   DIGITAL_SUPPLY_OK, ANALOG_SUPPLY_OK}; // R26
      pins <= pin_meta; // R26
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      en_d <= 1'b0;
      limp_d <= 1'b0;
    end else begin
      en_d <= pins.en;
      limp_d <= pins.limp;
    end
  end

  assign en_rise = pins.en && !en_d;

  always_comb begin
    next_state = state;
    if (!pins.ana_ok || (!pins.dig_ok && state != octal_driver_pkg::ST_LIMP)) begin
      next_state = octal_driver_pkg::ST_UVLO; // R9 R20
    end else begin
      case (state)
        octal_driver_pkg::ST_UVLO: begin
          if (pins.limp) begin
            next_state = octal_driver_pkg::ST_LIMP; // R11
          end else if (pins.en) begin
            next_state = octal_driver_pkg::ST_ACTIVE; // R23
          end else begin
            next_state = octal_driver_pkg::ST_LOW_IQ; // R12
          end
        end
        octal_driver_pkg::ST_LOW_IQ: begin
          if (pins.limp) begin
            next_state = octal_driver_pkg::ST_LIMP; // R23
          end else if (en_rise) begin
            next_state = octal_driver_pkg::ST_ACTIVE; // R22
          end
        end
        octal_driver_pkg::ST_ACTIVE: begin
          if (pins.limp) begin
            next_state = octal_driver_pkg::ST_LIMP; // R23
          end else if (!pins.en) begin
            next_state = octal_driver_pkg::ST_LOW_IQ; // R12
          end
        end
        octal_driver_pkg::ST_LIMP: begin
          if (!pins.limp) begin
            next_state = pins.en ? octal_driver_pkg::ST_ACTIVE
                                 : octal_driver_pkg::ST_LOW_IQ; // R19
          end
        end
        default: next_state = octal_driver_pkg::ST_UVLO;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state <= octal_driver_pkg::ST_UVLO;
    end else begin
      state <= next_state;
    end
  end

  // Any entry to global off is a full power-up of the register set
  assign enter_active = next_state == octal_driver_pkg::ST_ACTIVE &&
                        state != octal_driver_pkg::ST_ACTIVE; // R5
  assign wipe = state == octal_driver_pkg::ST_UVLO || enter_active ||
                (state == octal_driver_pkg::ST_LIMP && next_state != state) ||
                (state == octal_driver_pkg::ST_ACTIVE &&
                 next_state == octal_driver_pkg::ST_LOW_IQ); // R25
  // Entering limp-home also clears, so toggling limp-home re-enables channels
  assign clr_all = wipe || state == octal_driver_pkg::ST_LOW_IQ || // R25
                   (next_state == octal_driver_pkg::ST_LIMP &&
                    state != octal_driver_pkg::ST_LIMP); // R18
  // Writes outside global off are dropped, limp-home included
  assign wr_cmd = WR && ADDR == `REG_COMMAND &&
                  state == octal_driver_pkg::ST_ACTIVE; // R18

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      cmd <= `CMD_RESET; // R8
    end else if (wipe) begin
      cmd <= `CMD_RESET; // R5 R8 R19
    end else if (wr_cmd) begin
      cmd <= WDATA; // R24 R6
    end
  end

  // Set wins over the clear by a valid command
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      frame_error_flag <= 1'b1; // R8
    end else if (state == octal_driver_pkg::ST_UVLO || enter_active) begin
      frame_error_flag <= 1'b1; // R21
    end else if (wr_cmd) begin
      frame_error_flag <= 1'b0;
    end
  end

  // Diagnostic current stays off after power-up until software commands
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      diag_armed <= 1'b0; // R10
    end else if (wipe) begin
      diag_armed <= 1'b0; // R19
    end else if (wr_cmd) begin
      diag_armed <= 1'b1; // R10
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < 8; i++) begin
        ovl_cnt[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (!pins.ovl[i]) begin
          ovl_cnt[i] <= 8'h00; // R2
        end else if (ovl_cnt[i] != 8'(FILTER_CYCLES - 1)) begin
          ovl_cnt[i] <= ovl_cnt[i] + 8'h01; // R4
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      ovl_trip[i] = pins.ovl[i] && ovl_cnt[i] == 8'(FILTER_CYCLES - 1); // R2
    end
  end

  // A new fault beats a standby clear in the same cycle
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ovl_flt <= 8'h00;
      otp_flt <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (state == octal_driver_pkg::ST_UVLO) begin
          ovl_flt[i] <= 1'b0; // R3
          otp_flt[i] <= 1'b0;
        end else begin
          if (ovl_trip[i]) begin
            ovl_flt[i] <= 1'b1; // R1
          end else if (clr_all || standby_clear(state, cmd[2*i +: 2])) begin
            ovl_flt[i] <= 1'b0; // R3 R25 R16
          end
          if (pins.otp[i]) begin
            otp_flt[i] <= 1'b1; // R4
          end else if (clr_all || standby_clear(state, cmd[2*i +: 2])) begin
            otp_flt[i] <= 1'b0; // R3 R25
          end
        end
      end
    end
  end

  assign fault = ovl_flt | otp_flt;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      next_out[i] = 1'b0;
      next_diag[i] = 1'b0;
      case (state)
        octal_driver_pkg::ST_ACTIVE: begin
          next_out[i] = chan_drive(cmd[2*i +: 2], pins.par[i % 4]) && !fault[i]; // R14 R15 R6 R7 R1
          next_diag[i] = diag_armed && !next_out[i] &&
                         cmd[2*i +: 2] != octal_driver_pkg::CMD_STANDBY; // R7 R10
        end
        octal_driver_pkg::ST_LIMP: begin
          next_out[i] = (i < 4) ? (pins.par[i % 4] && !fault[i]) : 1'b0; // R17
        end
        default: begin
          next_out[i] = 1'b0; // R11 R12 R20
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      LOW_SIDE_OUTPUTS <= 8'h00;
      DIAG_CURRENT_EN <= 8'h00;
      REDUCED_IQ <= 1'b0;
    end else begin
      LOW_SIDE_OUTPUTS <= next_out;
      DIAG_CURRENT_EN <= next_diag;
      REDUCED_IQ <= state == octal_driver_pkg::ST_ACTIVE && cmd == `CMD_ALL_STANDBY; // R13
    end
  end

  assign MODE = state;

  // Read data stand in each cycle after RD is high, zero otherwise
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      RDATA <= 16'h0000;
    end else if (RD) begin
      RDATA <= read_mux(ADDR, cmd,
                        {ovl_flt[7], otp_flt[7], ovl_flt[6], otp_flt[6],
                         ovl_flt[5], otp_flt[5], ovl_flt[4], otp_flt[4],
                         ovl_flt[3], otp_flt[3], ovl_flt[2], otp_flt[2],
                         ovl_flt[1], otp_flt[1], ovl_flt[0], otp_flt[0]},
                        {frame_error_flag, diag_armed, REDUCED_IQ, state}); // R24
    end else begin
      RDATA <= 16'h0000;
    end
  end

  // Run length of overload samples on channel 1, kept apart from the filter counter
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ovl_run <= 9'h000;
    end else if (!pins.ovl[0]) begin
      ovl_run <= 9'h000;
    end else if (ovl_run != 9'h1ff) begin
      ovl_run <= ovl_run + 9'h001;
    end
  end

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  a_uvlo_cmd_default: assert property (state == octal_driver_pkg::ST_UVLO |=> // R8
    cmd == `CMD_RESET && frame_error_flag) else $error("defaults not restored");
  a_limp_exit_flag: assert property (state == octal_driver_pkg::ST_LIMP && // R21
    next_state == octal_driver_pkg::ST_ACTIVE |=> frame_error_flag && !diag_armed)
    else $error("limp exit did not set flag");
  a_ovl_filter_len: assert property ($rose(ovl_flt[0]) |-> // R2
    ovl_run >= 9'(FILTER_CYCLES))
    else $error("overload latched before filter time");
  a_fault_forces_off: assert property (fault[0] |=> !LOW_SIDE_OUTPUTS[0]) // R1
    else $error("faulted channel still driven");
  a_standby_clears: assert property (state == octal_driver_pkg::ST_ACTIVE && // R3
    cmd[1:0] == 2'b00 && !ovl_trip[0] && !pins.otp[0] |=> !fault[0])
    else $error("standby did not clear fault");
  a_limp_upper_off: assert property (state == octal_driver_pkg::ST_LIMP |=> // R17
    LOW_SIDE_OUTPUTS[7:4] == 4'h0) else $error("upper channels on in limp-home");
  a_limp_follow_in: assert property (state == octal_driver_pkg::ST_LIMP && // R17
    !fault[0] |=> LOW_SIDE_OUTPUTS[0] == $past(pins.par[0]))
    else $error("channel 1 not following");
  a_pair_follow_in: assert property (state == octal_driver_pkg::ST_ACTIVE && // R14
    cmd[9:8] == 2'b01 && !fault[4] |=> LOW_SIDE_OUTPUTS[4] == $past(pins.par[0]))
    else $error("channel 5 not paired with input 1");
  a_off_ignores_in: assert property (state == octal_driver_pkg::ST_ACTIVE && // R15
    cmd[9:8] == 2'b11 |=> !LOW_SIDE_OUTPUTS[4]) else $error("off channel driven");
  a_uvlo_all_off: assert property (state == octal_driver_pkg::ST_UVLO |=> // R20
    LOW_SIDE_OUTPUTS == 8'h00) else $error("outputs on in undervoltage");
  a_en_rise_reset: assert property (state == octal_driver_pkg::ST_LOW_IQ && // R22
    en_rise && !pins.limp && pins.ana_ok && pins.dig_ok |=>
    state == octal_driver_pkg::ST_ACTIVE && cmd == `CMD_RESET && frame_error_flag)
    else $error("enable rise not handled");
  a_limp_ignore_wr: assert property (state == octal_driver_pkg::ST_LIMP && // R18
    next_state == octal_driver_pkg::ST_LIMP |=> $stable(cmd))
    else $error("command taken in limp-home");
  a_low_iq_entry: assert property (state == octal_driver_pkg::ST_ACTIVE && // R12
    !pins.en && !pins.limp && pins.ana_ok && pins.dig_ok |=>
    state == octal_driver_pkg::ST_LOW_IQ) else $error("low quiescent state not entered");
  a_reduced_iq: assert property (state == octal_driver_pkg::ST_ACTIVE && // R13
    cmd == `CMD_ALL_STANDBY |=> REDUCED_IQ) else $error("reduced current not shown");
  a_diag_standby_off: assert property (state == octal_driver_pkg::ST_ACTIVE && // R7
    cmd[1:0] == 2'b00 |=> !DIAG_CURRENT_EN[0]) else $error("diag current in standby");
  a_diag_powerup_off: assert property (!diag_armed |=> DIAG_CURRENT_EN == 8'h00) // R10
    else $error("diag current before first command");
  a_limp_exit_wipe: assert property (state == octal_driver_pkg::ST_LIMP && // R19
    next_state != octal_driver_pkg::ST_LIMP |=> cmd == `CMD_RESET && !diag_armed)
    else $error("registers kept after limp-home");
  a_limp_entry_any: assert property (pins.limp && pins.ana_ok && pins.dig_ok && // R23
    (state == octal_driver_pkg::ST_ACTIVE || state == octal_driver_pkg::ST_LOW_IQ) |=>
    state == octal_driver_pkg::ST_LIMP) else $error("limp-home not entered");
  a_en_low_clear: assert property (state == octal_driver_pkg::ST_LOW_IQ && // R25
    ovl_trip == 8'h00 && pins.otp == 8'h00 |=> fault == 8'h00)
    else $error("faults kept with enable low");
  a_uvlo_fault_clear: assert property (state == octal_driver_pkg::ST_UVLO |=> // R25
    fault == 8'h00) else $error("faults kept in undervoltage");
  a_on_drives_out: assert property (state == octal_driver_pkg::ST_ACTIVE && // R6
    cmd[1:0] == 2'b10 && !fault[0] |=> LOW_SIDE_OUTPUTS[0])
    else $error("channel 1 not on");
  a_rdata_idle: assert property (!RD |=> RDATA == 16'h0000) // R24
    else $error("read data outside read cycle");

  c_limp_entry: cover property (state == octal_driver_pkg::ST_ACTIVE ##1
    state == octal_driver_pkg::ST_LIMP);
  c_ovl_latch: cover property ($rose(ovl_flt[0]));
  c_all_standby: cover property ($rose(REDUCED_IQ));
  c_en_wake: cover property (state == octal_driver_pkg::ST_LOW_IQ ##1
    state == octal_driver_pkg::ST_ACTIVE);

endmodule
`default_nettype wire

// ---- dv/octal_host_model.sv ----
// Host model that drives the register port of the driver block
`timescale 1ns/1ps
`default_nettype none
module octal_host_model (
  input wire logic clk,
  input wire logic [15:0] rdata,
  output logic [3:0] addr,
  output logic [15:0] wdata,
  output logic wr,
  output logic rd
);
  initial begin
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end
  // Released bus lines show inverted values so stale data never looks valid
  task automatic put(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  task automatic get(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    #1 d = rdata;
  endtask
  // Standby on one channel, then the old command back
  task automatic clear_chan(input int ch, input logic [15:0] cmd);
    put(4'h0, cmd & ~(16'h0003 << (2 * ch)));
    put(4'h0, cmd);
  endtask
endmodule
`default_nettype wire

// ---- dv/octal_driver_channel_mode_control_tb_top.sv ----
// Self-checking bench for the driver channel mode control block
`timescale 1ns/1ps
`default_nettype none
module octal_driver_channel_mode_control_tb_top;
  localparam int FILT = 4;
  logic clk, rst, en, limp, dig, ana, wr, rd, riq;
  logic [3:0] par, addr;
  logic [7:0] ovl, otp, outs, diag;
  logic [15:0] wdata, rdata, d, cmd;
  logic [1:0] mode;
  int err_total = 0;
  int checks = 0;

  octal_driver_channel_mode_control #(.FILTER_CYCLES(FILT)) uut (
    .REF_CLK(clk), .RST(rst), .EN(en), .LIMP_HOME_INPUT(limp), .PAR_IN(par),
    .OVERLOAD_DET(ovl), .OVERTEMP_DET(otp), .DIGITAL_SUPPLY_OK(dig),
    .ANALOG_SUPPLY_OK(ana), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .LOW_SIDE_OUTPUTS(outs), .DIAG_CURRENT_EN(diag),
    .REDUCED_IQ(riq), .MODE(mode));
  octal_host_model host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd));

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded wait: a stuck state machine shows as a mismatch, not a hang
  task automatic wait_mode(input logic [1:0] m);
    int i;
    i = 0;
    while (mode !== m && i < 60) begin
      cyc(1);
      i++;
    end
    chk("mode", {14'h0, m}, {14'h0, mode});
  endtask
  function automatic logic [7:0] model(input logic [15:0] c, input logic [3:0] p,
                                       input logic lh);
    logic [7:0] o;
    for (int i = 0; i < 8; i++) begin
      if (lh) o[i] = (i < 4) ? p[i] : 1'b0;
      else if (c[2*i+:2] == 2'b10) o[i] = 1'b1;
      else if (c[2*i+:2] == 2'b01) o[i] = p[i%4];
      else o[i] = 1'b0;
    end
    return o;
  endfunction
  // Sink current on every channel that is neither standby nor driven
  function automatic logic [7:0] diag_model(input logic [15:0] c, input logic [7:0] o);
    logic [7:0] g;
    for (int i = 0; i < 8; i++) g[i] = c[2*i+:2] != 2'b00 && !o[i];
    return g;
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #400000;
    err_total++;
    close_out();
  end
  initial begin
    rst = 1'b1;
    en = 1'b1;
    limp = 1'b0;
    par = 4'h0;
    ovl = 8'h00;
    otp = 8'h00;
    dig = 1'b1;
    ana = 1'b1;
    void'($urandom(16));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wait_mode(2'b10);
    host.get(4'h0, d);
    chk("cmd", 16'hffff, d);
    host.get(4'h4, d);
    chk("fault", 16'h0000, d);
    host.get(4'h8, d);
    chk("modereg", 16'h0012, d);
    chk("diag", 16'h0000, {8'h0, diag});
    $display("test defaults done");
    for (int k = 0; k < 12; k++) begin
      cmd = (k < 4) ? {8{2'(k)}} : 16'($urandom);
      @(posedge clk);
      par <= 4'($urandom);
      host.put(4'h0, cmd);
      cyc(6);
      chk("outs", {8'h0, model(cmd, par, 1'b0)}, {8'h0, outs});
      chk("riq", {15'h0, cmd == 16'h0}, {15'h0, riq});
      if (k == 0) chk("diag", 16'h0000, {8'h0, diag});
      chk("diagmap", {8'h0, diag_model(cmd, model(cmd, par, 1'b0))}, {8'h0, diag});
    end
    host.get(4'h8, d);
    chk("modereg", {11'h0, 2'b01, cmd == 16'h0, 2'b10}, d);
    host.get(4'hc, d);
    chk("unmapped", 16'h0000, d);
    host.put(4'h8, 16'h0000);
    host.get(4'h0, d);
    chk("cmd", cmd, d);
    $display("test commands done");
    host.put(4'h0, 16'h0002);
    @(posedge clk);
    ovl <= 8'h01;
    repeat (FILT - 1) @(posedge clk);
    ovl <= 8'h00;
    cyc(8);
    chk("spike", 16'h0001, {8'h0, outs});
    @(posedge clk);
    ovl <= 8'h01;
    cyc(FILT + 6);
    chk("trip", 16'h0000, {8'h0, outs});
    @(posedge clk);
    ovl <= 8'h00;
    cyc(6);
    chk("latched", 16'h0000, {8'h0, outs});
    host.get(4'h4, d);
    chk("fault", 16'h0002, d);
    host.clear_chan(0, 16'h0002);
    cyc(4);
    host.get(4'h4, d);
    chk("cleared", 16'h0000, d);
    chk("again", 16'h0001, {8'h0, outs});
    host.put(4'h0, 16'h0008);
    @(posedge clk);
    otp <= 8'h02;
    cyc(6);
    @(posedge clk);
    otp <= 8'h00;
    host.get(4'h4, d);
    chk("hot", 16'h0004, d);
    chk("hotoff", 16'h0000, {8'h0, outs});
    $display("test faults done");
    @(posedge clk);
    par <= 4'h5;
    limp <= 1'b1;
    wait_mode(2'b11);
    cyc(4);
    chk("limp", {8'h0, model(cmd, par, 1'b1)}, {8'h0, outs});
    host.put(4'h0, 16'haaaa);
    cyc(6);
    chk("ignore", 16'h0005, {8'h0, outs});
    @(posedge clk);
    ovl <= 8'h01;
    cyc(FILT + 6);
    @(posedge clk);
    ovl <= 8'h00;
    cyc(4);
    chk("limptrip", 16'h0004, {8'h0, outs});
    @(posedge clk);
    dig <= 1'b0;
    cyc(8);
    chk("digdrop", 16'h0003, {14'h0, mode});
    @(posedge clk);
    dig <= 1'b1;
    host.get(4'h4, d);
    chk("kept", 16'h0002, d);
    @(posedge clk);
    ana <= 1'b0;
    wait_mode(2'b00);
    cyc(1);
    chk("uvoff", 16'h0000, {8'h0, outs});
    @(posedge clk);
    ana <= 1'b1;
    wait_mode(2'b11);
    cyc(4);
    chk("relimp", 16'h0005, {8'h0, outs});
    @(posedge clk);
    limp <= 1'b0;
    wait_mode(2'b10);
    host.get(4'h0, d);
    chk("cmd", 16'hffff, d);
    host.get(4'h8, d);
    chk("modereg", 16'h0012, d);
    host.get(4'h4, d);
    chk("fault", 16'h0000, d);
    chk("diag", 16'h0000, {8'h0, diag});
    $display("test limp done");
    host.put(4'h0, 16'h0002);
    @(posedge clk);
    en <= 1'b0;
    wait_mode(2'b01);
    cyc(1);
    chk("lowiq", 16'h0000, {8'h0, outs});
    @(posedge clk);
    en <= 1'b1;
    wait_mode(2'b10);
    host.get(4'h0, d);
    chk("cmd", 16'hffff, d);
    host.get(4'h8, d);
    chk("modereg", 16'h0012, d);
    @(posedge clk);
    dig <= 1'b0;
    wait_mode(2'b00);
    @(posedge clk);
    dig <= 1'b1;
    wait_mode(2'b10);
    $display("test enable done");
    close_out();
  end
endmodule
`default_nettype wire
